// ==== rtl/dual_timer_capture_reload.v ====
// second timer module: aux_timer, core_timer and capture_reload_reg
// assumes a single system clock; pins arrive synchronous but are resynchronised anyway
//
// Overview of operation
// - finest count rate is two system clocks
// - two timers plus one shared capture register
// - timers and capture register are 16 bits
// - clock from prescaler or external input
// - direction from software bit or pin
// - core overflow/underflow inverts toggle latch
// - aux may count on toggle latch transitions
// - toggle latch optionally driven on pin
// - core overflows clock compare unit timers
// - reload core from capture register on overflow
// - capture aux value on selected pin edge
// - optionally clear aux after capture
// - first module inputs as capture trigger
`timescale 1ns/100ps
`include "dual_timer_map.vh"

module dual_timer_capture_reload (
  input wire clock,
  input wire nrst,
  input wire [`ADDR_W-1:0] address,
  input wire [`DATA_W-1:0] writeData,
  input wire writeStrobe,
  input wire readStrobe,
  output reg [`DATA_W-1:0] readData,
  input wire auxCountIn,
  input wire auxDirectionIn,
  input wire coreCountIn,
  input wire coreDirectionIn,
  input wire captureInPin,
  input wire firstModuleCountIn,
  input wire firstModuleDirectionIn,
  output reg toggleOutPin,
  output reg compareUnitTimersClock
);

  // bit positions of the pins in the synchroniser bank
  localparam NUM_IN = 7;
  localparam IDX_AUX_CNT = 0;
  localparam IDX_AUX_DIR = 1;
  localparam IDX_CORE_CNT = 2;
  localparam IDX_CORE_DIR = 3;
  localparam IDX_CAP = 4;
  localparam IDX_FIRST_CNT = 5;
  localparam IDX_FIRST_DIR = 6;

  reg [15:0] auxTimer;
  reg [15:0] coreTimer;
  reg [15:0] captureReloadReg;
  reg [15:0] auxCtrl;
  reg [15:0] coreCtrl;
  reg coreToggleLatch;
  reg [7:0] prescCount;

  wire [NUM_IN-1:0] rawIn;
  wire [NUM_IN-1:0] syncIn;
  wire [NUM_IN-1:0] riseIn;
  wire [NUM_IN-1:0] fallIn;

  assign rawIn = {firstModuleDirectionIn, firstModuleCountIn, captureInPin,
    coreDirectionIn, coreCountIn, auxDirectionIn, auxCountIn};

  // two flops per pin, then a third flop only used for edge detection
  // edge flops reset low, so a pin that idles high shows one false rise after reset
  genvar gi;
  generate
    for (gi = 0; gi < NUM_IN; gi = gi + 1)
    begin : syncStage
      reg meta;
      reg stable;
      reg delayed;
      always @(posedge clock)
      begin
        if (!nrst)
        begin
          meta <= 1'b0;
          stable <= 1'b0;
          delayed <= 1'b0;
        end
        else
        begin
          meta <= rawIn[gi];
          stable <= meta;
          delayed <= stable;
        end
      end
      assign syncIn[gi] = stable;
      assign riseIn[gi] = stable & ~delayed;
      assign fallIn[gi] = ~stable & delayed;
    end
  endgenerate

  // prescaler tap: period is 2^(sel+1) clocks, so sel 0 gives one tick per two clocks
  function prescTick;
    input [7:0] cnt;
    input [2:0] sel;
    integer i;
    begin
      prescTick = 1'b1;
      for (i = 0; i < 8; i = i + 1)
        if ((i <= sel) && !cnt[i])
          prescTick = 1'b0;
    end
  endfunction

  // edge select: 1 rising, 2 falling, 3 both, 0 none
  function edgeHit;
    input [1:0] mode;
    input rise;
    input fall;
    begin
      edgeHit = (mode[0] & rise) | (mode[1] & fall);
    end
  endfunction

  // direction: external pin level (high counts down) or software bit
  function countDown;
    input useExt;
    input softDown;
    input pinLevel;
    begin
      countDown = useExt ? pinLevel : softDown;
    end
  endfunction

  // register select, shared by all write decodes
  function regHit;
    input [`ADDR_W-1:0] addr;
    input [`ADDR_W-1:0] ofs;
    begin
      regHit = (addr == ofs);
    end
  endfunction

  wire wrAux = writeStrobe && regHit(address, `OFS_AUX_TIMER);
  wire wrCore = writeStrobe && regHit(address, `OFS_CORE_TIMER);
  wire wrCap = writeStrobe && regHit(address, `OFS_CAPTURE_RELOAD_REG);
  wire wrAuxCtrl = writeStrobe && regHit(address, `OFS_AUX_CTRL);
  wire wrCoreCtrl = writeStrobe && regHit(address, `OFS_CORE_CTRL);

  // core timer
  wire coreDown = countDown(coreCtrl[`CORE_DIREXT], coreCtrl[`CORE_DOWN],
    syncIn[IDX_CORE_DIR]);
  wire coreSrcTick = coreCtrl[`CORE_CLKEXT] ? riseIn[IDX_CORE_CNT] :
    prescTick(prescCount, coreCtrl[`CORE_PRE_HI:`CORE_PRE_LO]);
  wire coreTick = coreCtrl[`CORE_RUN] & coreSrcTick;
  // wrap is judged on the tick itself, so reload, latch and aux step share one cycle
  wire coreWrap = coreTick & (coreDown ? (coreTimer == `TIMER_RESET) :
    (coreTimer == `TIMER_MAX));
  wire [15:0] coreStep = coreDown ? coreTimer - 16'h0001 : coreTimer + 16'h0001;

  // aux timer
  wire [1:0] auxClkSel = auxCtrl[`AUX_CLK_HI:`AUX_CLK_LO];
  wire auxDown = countDown(auxCtrl[`AUX_DIREXT], auxCtrl[`AUX_DOWN],
    syncIn[IDX_AUX_DIR]);
  // clock code 3 parks the aux timer without touching its run bit
  reg auxSrcTick;
  always @*
  begin
    case (auxClkSel)
      `CLK_PRESC: auxSrcTick = prescTick(prescCount, auxCtrl[`AUX_PRE_HI:`AUX_PRE_LO]);
      `CLK_EXT: auxSrcTick = riseIn[IDX_AUX_CNT];
      `CLK_LATCH: auxSrcTick = coreWrap;
      default: auxSrcTick = 1'b0;
    endcase
  end
  wire auxTick = auxCtrl[`AUX_RUN] & auxSrcTick;
  wire [15:0] auxStep = auxDown ? auxTimer - 16'h0001 : auxTimer + 16'h0001;

  // capture trigger
  // capture and clear act three edges after the pin moves, in the edge-detect cycle
  wire [1:0] capEdge = auxCtrl[`AUX_EDGE_HI:`AUX_EDGE_LO];
  reg capTrig;
  always @*
  begin
    case (auxCtrl[`AUX_SRC_HI:`AUX_SRC_LO])
      `SRC_PIN: capTrig = edgeHit(capEdge, riseIn[IDX_CAP], fallIn[IDX_CAP]);
      `SRC_FIRST_CNT: capTrig = edgeHit(capEdge, riseIn[IDX_FIRST_CNT],
        fallIn[IDX_FIRST_CNT]);
      `SRC_FIRST_DIR: capTrig = edgeHit(capEdge, riseIn[IDX_FIRST_DIR],
        fallIn[IDX_FIRST_DIR]);
      `SRC_FIRST_BOTH: capTrig = edgeHit(capEdge, riseIn[IDX_FIRST_CNT],
        fallIn[IDX_FIRST_CNT]) | edgeHit(capEdge, riseIn[IDX_FIRST_DIR],
        fallIn[IDX_FIRST_DIR]);
      default: capTrig = 1'b0;
    endcase
  end
  wire capture = auxCtrl[`AUX_CAPEN] & capTrig;

  // free running: the first tick after a control write may come early in its period
  always @(posedge clock)
  begin
    if (!nrst)
      prescCount <= 8'h00;
    else
      prescCount <= prescCount + 8'h01;
  end

  always @(posedge clock)
  begin
    if (!nrst)
    begin
      auxCtrl <= `CTRL_RESET;
      coreCtrl <= `CTRL_RESET;
    end
    else
    begin
      if (wrAuxCtrl)
        auxCtrl <= writeData & `AUX_CTRL_MASK;
      if (wrCoreCtrl)
        coreCtrl <= writeData & `CORE_CTRL_MASK;
    end
  end

  // software write loads the timer; otherwise a wrap with reload set loads the capture register, else it steps on its tick
  always @(posedge clock)
  begin
    if (!nrst)
      coreTimer <= `TIMER_RESET;
    else if (wrCore)
      coreTimer <= writeData;
    else if (coreWrap && coreCtrl[`CORE_RELOAD])
      coreTimer <= captureReloadReg;
    else if (coreTick)
      coreTimer <= coreStep;
  end

  // clear-on-capture overrides both counting and a same-cycle write
  always @(posedge clock)
  begin
    if (!nrst)
      auxTimer <= `TIMER_RESET;
    else if (capture && auxCtrl[`AUX_CLRCAP])
      auxTimer <= `TIMER_RESET;
    else if (wrAux)
      auxTimer <= writeData;
    else if (auxTick)
      auxTimer <= auxStep;
  end

  // hardware capture wins over a software write landing in the same cycle
  always @(posedge clock)
  begin
    if (!nrst)
      captureReloadReg <= `TIMER_RESET;
    else if (capture)
      captureReloadReg <= auxTimer;
    else if (wrCap)
      captureReloadReg <= writeData;
  end

  // latch is writable for initial phase; a wrap in the same cycle inverts the written value
  always @(posedge clock)
  begin
    if (!nrst)
      coreToggleLatch <= 1'b0;
    else if (wrCoreCtrl)
      coreToggleLatch <= writeData[`CORE_LATCH] ^ coreWrap;
    else if (coreWrap)
      coreToggleLatch <= ~coreToggleLatch;
  end

  always @(posedge clock)
  begin
    if (!nrst)
    begin
      toggleOutPin <= 1'b0;
      compareUnitTimersClock <= 1'b0;
    end
    else
    begin
      toggleOutPin <= coreCtrl[`CORE_OUTEN] & coreToggleLatch;
      compareUnitTimersClock <= coreWrap;
    end
  end

  // read data stand only in the cycle after the strobe; unmapped reads return zero
  // core control reads back the live latch, not the bit last written
  always @(posedge clock)
  begin
    if (!nrst)
      readData <= 16'h0000;
    else if (readStrobe)
    begin
      case (address)
        `OFS_AUX_TIMER: readData <= auxTimer;
        `OFS_CORE_TIMER: readData <= coreTimer;
        `OFS_CAPTURE_RELOAD_REG: readData <= captureReloadReg;
        `OFS_AUX_CTRL: readData <= auxCtrl;
        `OFS_CORE_CTRL: readData <= {coreCtrl[15:10], coreToggleLatch, coreCtrl[8:0]};
        default: readData <= 16'h0000;
      endcase
    end
    else
      readData <= 16'h0000;
  end

endmodule

// ==== pkg/dual_timer_map.vh ====
// register map, field positions and reset values of the dual timer block
// assumes a 16-bit plain register port with byte offsets on an 8-bit address
`ifndef DUAL_TIMER_MAP_VH
`define DUAL_TIMER_MAP_VH

`define ADDR_W 8
`define DATA_W 16

`define OFS_AUX_TIMER 8'h00
`define OFS_CORE_TIMER 8'h04
`define OFS_CAPTURE_RELOAD_REG 8'h08
`define OFS_AUX_CTRL 8'h0c
`define OFS_CORE_CTRL 8'h10

// aux control fields
`define AUX_RUN 0
`define AUX_DOWN 1
`define AUX_DIREXT 2
`define AUX_CLK_LO 3
`define AUX_CLK_HI 4
`define AUX_PRE_LO 5
`define AUX_PRE_HI 7
`define AUX_CAPEN 8
`define AUX_EDGE_LO 9
`define AUX_EDGE_HI 10
`define AUX_SRC_LO 11
`define AUX_SRC_HI 12
`define AUX_CLRCAP 13
`define AUX_CTRL_MASK 16'h3fff

// aux clock source codes
`define CLK_PRESC 2'h0
`define CLK_EXT 2'h1
`define CLK_LATCH 2'h2

// capture source codes
`define SRC_PIN 2'h0
`define SRC_FIRST_CNT 2'h1
`define SRC_FIRST_DIR 2'h2
`define SRC_FIRST_BOTH 2'h3

// core control fields
`define CORE_RUN 0
`define CORE_DOWN 1
`define CORE_DIREXT 2
`define CORE_CLKEXT 3
`define CORE_PRE_LO 4
`define CORE_PRE_HI 6
`define CORE_RELOAD 7
`define CORE_OUTEN 8
`define CORE_LATCH 9
`define CORE_CTRL_MASK 16'h03ff

`define TIMER_RESET 16'h0000
`define CTRL_RESET 16'h0000
`define TIMER_MAX 16'hffff

`endif

// ==== bench/event_pins.sv ====
// far-side pins: capture pin, first module inputs, count and direction pins of both timers
// assumes the caller runs flip from its own thread
`timescale 1ns/100ps
module event_pins (
  input wire clock,
  output reg capPin,
  output reg fCnt,
  output reg fDir,
  output reg aCnt,
  output reg cDir,
  output reg aDir,
  output reg cCnt
);
  initial {capPin, fCnt, fDir, aCnt, cDir, aDir, cCnt} = 7'h00;
  // each level is held at least five clocks so the synchroniser never misses it
  task flip(input integer k);
    begin
      @(posedge clock);
      case (k)
        0: capPin <= !capPin;
        1: fCnt <= !fCnt;
        2: fDir <= !fDir;
        3: aCnt <= !aCnt;
        4: cDir <= !cDir;
        5: aDir <= !aDir;
        default: cCnt <= !cCnt;
      endcase
      repeat (4) @(posedge clock);
    end
  endtask
endmodule

// ==== bench/dual_timer_sva.sv ====
// port assertions for the dual timer block
// assumes the map header on the include path
`timescale 1ns/100ps
`include "dual_timer_map.vh"
module dual_timer_sva (
  input wire clock,
  input wire nrst,
  input wire [7:0] address,
  input wire [15:0] writeData,
  input wire writeStrobe,
  input wire readStrobe,
  input wire [15:0] readData,
  input wire toggleOutPin,
  input wire compareUnitTimersClock
);
  default clocking @(posedge clock); endclocking
  default disable iff (!nrst);
  property p_idle; !$past(readStrobe) |-> readData == 16'h0; endproperty
  property p_hole; readStrobe && address == 8'h14 |=> readData == 16'h0; endproperty
  property p_amask; readStrobe && address == `OFS_AUX_CTRL |=> readData[15:14] == 2'h0; endproperty
  property p_cmask; readStrobe && address == `OFS_CORE_CTRL |=> readData[15:10] == 6'h0; endproperty
  property p_back;
    writeStrobe && address == `OFS_AUX_CTRL ##2 readStrobe && address == `OFS_AUX_CTRL
      |=> readData == ($past(writeData, 3) & `AUX_CTRL_MASK);
  endproperty
  property p_pulse; compareUnitTimersClock |=> !compareUnitTimersClock; endproperty
  // the pin moves a cycle after a wrap pulse or two cycles after a core control write
  property p_tog;
    $changed(toggleOutPin) |->
      $past(compareUnitTimersClock) || $past(writeStrobe, 2) && $past(address, 2) == `OFS_CORE_CTRL;
  endproperty
  property p_rst;
    disable iff (1'b0) !nrst |=> readData == 16'h0 && !toggleOutPin && !compareUnitTimersClock;
  endproperty
  a_idle: assert property (p_idle) else $error("read data outside read slot");
  a_hole: assert property (p_hole) else $error("unmapped read not zero");
  a_amask: assert property (p_amask) else $error("aux control spare bits set");
  a_cmask: assert property (p_cmask) else $error("core control spare bits set");
  a_back: assert property (p_back) else $error("aux control readback wrong");
  a_pulse: assert property (p_pulse) else $error("compare clock wider than one");
  a_tog: assert property (p_tog) else $error("toggle pin moved without cause");
  a_rst: assert property (p_rst) else $error("outputs not cleared by reset");
  c_wrap: cover property (compareUnitTimersClock);
  c_tog: cover property ($rose(toggleOutPin));
  c_cap: cover property (readStrobe && address == `OFS_CAPTURE_RELOAD_REG);
endmodule
bind dual_timer_capture_reload dual_timer_sva i_sva (.clock(clock), .nrst(nrst),
  .address(address), .writeData(writeData), .writeStrobe(writeStrobe),
  .readStrobe(readStrobe), .readData(readData), .toggleOutPin(toggleOutPin),
  .compareUnitTimersClock(compareUnitTimersClock));

// ==== bench/tb.sv ====
// self-checking bench for the dual timer block
// assumes one 100 MHz clock; the partner drives the event pins
`timescale 1ns/100ps
`include "dual_timer_map.vh"
`define CHK(a, b) begin nTests++; if ((a) !== (b)) begin nFail++; \
  $display("mismatch %0t got %h want %h", $time, a, b); end end
module tb;
  logic clock = 1'b0;
  logic nrst = 1'b0;
  logic [7:0] address = 8'h00;
  logic [15:0] writeData = 16'h0000;
  logic writeStrobe = 1'b0;
  logic readStrobe = 1'b0;
  logic lastTog = 1'b0;
  logic [15:0] v1, v2;
  wire [15:0] readData;
  wire tog, cmp, capPin, fCnt, fDir, aCnt, cDir, aDir, cCnt;
  integer nFail = 0, nTests = 0, nPulse = 0, nTog = 0;
  initial forever #5 clock = !clock;
  event_pins i_ev (.clock(clock), .capPin(capPin), .fCnt(fCnt), .fDir(fDir), .aCnt(aCnt),
    .cDir(cDir), .aDir(aDir), .cCnt(cCnt));
  dual_timer_capture_reload i_dut (.clock(clock), .nrst(nrst), .address(address),
    .writeData(writeData), .writeStrobe(writeStrobe), .readStrobe(readStrobe),
    .readData(readData), .auxCountIn(aCnt), .auxDirectionIn(aDir), .coreCountIn(cCnt),
    .coreDirectionIn(cDir), .captureInPin(capPin), .firstModuleCountIn(fCnt),
    .firstModuleDirectionIn(fDir), .toggleOutPin(tog), .compareUnitTimersClock(cmp));
  always @(posedge clock)
  begin
    if (cmp) nPulse <= nPulse + 1;
    if (tog !== lastTog) nTog <= nTog + 1;
    lastTog <= tog;
  end
  task wr(input logic [7:0] a, input logic [15:0] d);
    begin
      @(posedge clock);
      address <= a;
      writeData <= d;
      writeStrobe <= 1'b1;
      @(posedge clock);
      writeStrobe <= 1'b0;
    end
  endtask
  task rd(input logic [7:0] a, output logic [15:0] d);
    begin
      @(posedge clock);
      address <= a;
      readStrobe <= 1'b1;
      @(posedge clock);
      readStrobe <= 1'b0;
      #1 d = readData;
    end
  endtask
  task ck(input logic [7:0] a, input logic [15:0] e);
    begin
      rd(a, v1);
      `CHK(v1, e)
    end
  endtask
  task t_regs;
    integer i;
    begin
      for (i = 0; i < 24; i += 4) ck(8'(i), 16'h0000);
      wr(`OFS_AUX_CTRL, 16'hffff);
      ck(`OFS_AUX_CTRL, `AUX_CTRL_MASK);
      wr(`OFS_AUX_CTRL, 16'h0000);
      wr(`OFS_CORE_TIMER, 16'h1234);
      repeat (20) @(posedge clock);
      ck(`OFS_CORE_TIMER, 16'h1234);
    end
  endtask
  // up, soft down, pin down: ten clocks give five counts either way
  task t_dir;
    integer i;
    begin
      i_ev.flip(4);
      for (i = 0; i < 3; i++)
      begin
        wr(`OFS_CORE_CTRL, 16'(1 + 2 * i));
        rd(`OFS_CORE_TIMER, v1);
        repeat (8) @(posedge clock);
        rd(`OFS_CORE_TIMER, v2);
        `CHK(16'(v2 - v1), (i ? 16'hfffb : 16'h0005))
      end
      wr(`OFS_CORE_CTRL, 16'h0000);
    end
  endtask
  task t_wrap;
    begin
      wr(`OFS_CAPTURE_RELOAD_REG, 16'hfffe);
      wr(`OFS_CORE_TIMER, 16'hfffe);
      wr(`OFS_CORE_CTRL, 16'h0181);
      wr(`OFS_AUX_TIMER, 16'h0000);
      wr(`OFS_AUX_CTRL, 16'h0011);
      rd(`OFS_AUX_TIMER, v1);
      nPulse = 0;
      nTog = 0;
      repeat (38) @(posedge clock);
      rd(`OFS_AUX_TIMER, v2);
      `CHK(16'(v2 - v1), 16'h000a)
      `CHK(nPulse, 10)
      `CHK(nTog, 10)
      wr(`OFS_CORE_CTRL, 16'h0000);
      wr(`OFS_AUX_CTRL, 16'h0000);
      wr(`OFS_CORE_CTRL, 16'h0200);
      repeat (2) @(posedge clock);
      `CHK(tog, 1'b0)
      wr(`OFS_CORE_CTRL, 16'h0300);
      repeat (2) @(posedge clock);
      `CHK(tog, 1'b1)
      wr(`OFS_CORE_CTRL, 16'h0000);
    end
  endtask
  // pin clock and pin direction, falling-edge and dual-source capture, slower prescale
  task t_pins;
    begin
      wr(`OFS_CORE_TIMER, 16'hffff);
      nPulse = 0;
      wr(`OFS_CORE_CTRL, 16'h0009);
      repeat (6) i_ev.flip(6);
      ck(`OFS_CORE_TIMER, 16'h0002);
      `CHK(nPulse, 1)
      wr(`OFS_CORE_CTRL, 16'h0000);
      i_ev.flip(5);
      wr(`OFS_AUX_TIMER, 16'h0010);
      wr(`OFS_AUX_CTRL, 16'h000d);
      repeat (4) i_ev.flip(3);
      ck(`OFS_AUX_TIMER, 16'h000e);
      wr(`OFS_AUX_CTRL, 16'h1d00);
      i_ev.flip(1);
      ck(`OFS_CAPTURE_RELOAD_REG, 16'h000e);
      wr(`OFS_AUX_TIMER, 16'h0777);
      i_ev.flip(2);
      ck(`OFS_CAPTURE_RELOAD_REG, 16'h0777);
      wr(`OFS_AUX_TIMER, 16'h0000);
      wr(`OFS_AUX_CTRL, 16'h0021);
      rd(`OFS_AUX_TIMER, v1);
      repeat (10) @(posedge clock);
      rd(`OFS_AUX_TIMER, v2);
      `CHK(16'(v2 - v1), 16'h0003)
      wr(`OFS_AUX_CTRL, 16'h0000);
    end
  endtask
  task t_cap;
    begin
      wr(`OFS_AUX_TIMER, 16'h0abc);
      wr(`OFS_AUX_CTRL, 16'h2300);
      i_ev.flip(0);
      ck(`OFS_CAPTURE_RELOAD_REG, 16'h0abc);
      ck(`OFS_AUX_TIMER, 16'h0000);
      wr(`OFS_AUX_TIMER, 16'h0555);
      i_ev.flip(0);
      ck(`OFS_CAPTURE_RELOAD_REG, 16'h0abc);
      wr(`OFS_AUX_CTRL, 16'h0f00);
      i_ev.flip(1);
      ck(`OFS_CAPTURE_RELOAD_REG, 16'h0555);
      wr(`OFS_AUX_TIMER, 16'h0666);
      wr(`OFS_AUX_CTRL, 16'h1700);
      i_ev.flip(2);
      ck(`OFS_CAPTURE_RELOAD_REG, 16'h0666);
      wr(`OFS_AUX_TIMER, 16'h0000);
      wr(`OFS_AUX_CTRL, 16'h0009);
      repeat (6) i_ev.flip(3);
      ck(`OFS_AUX_TIMER, 16'h0003);
    end
  endtask
  task closeOut;
    begin
      if (nFail == 0 && nTests > 0)
        $display("Result: passed");
      else
        $display("Result: failed");
      $finish;
    end
  endtask
  initial
  begin
    repeat (16) @(posedge clock);
    nrst <= 1'b1;
    t_regs;
    t_dir;
    t_wrap;
    t_cap;
    t_pins;
    closeOut;
  end
  initial
  begin
    #100000;
    nFail++;
    closeOut;
  end
endmodule
